// >>> design/can_cfg.svh
// Constants of the CAN bit timing and identifier configuration block.
// Assumes a 40 MHz aclk and a 32-bit AXI4-Lite register port.
`ifndef CAN_CFG_SVH
`define CAN_CFG_SVH

// ****************************************
// Clocking
// ****************************************
`define CFG_CLK_HZ          40000000
`define CFG_REF_HZ          8000000
`define CFG_CLKS_PER_REF    (`CFG_CLK_HZ / `CFG_REF_HZ)
`define CFG_QUANTA_MIN      5'd8
`define CFG_QUANTA_MAX      5'd23
`define CFG_EDGE_MAX        7'd64
`define CFG_ADDR_BCAST      6'd33

// ****************************************
// Register offsets
// ****************************************
`define CFG_OFF_TIMING      8'h00
`define CFG_OFF_ID_LOW      8'h04
`define CFG_OFF_ID_MID      8'h08
`define CFG_OFF_ID_HIGH     8'h0c
`define CFG_OFF_FIELD       8'h10
`define CFG_OFF_ADDR        8'h14
`define CFG_OFF_STATUS      8'h18

// ****************************************
// Field positions
// ****************************************
`define CFG_TIM_PRESC_LSB   0
`define CFG_TIM_SEG1_LSB    8
`define CFG_TIM_SEG2_LSB    12
`define CFG_ID_STD_BIT      31
`define CFG_FLD_START_LSB   0
`define CFG_FLD_LEFT_BIT    7
`define CFG_FLD_COUNT_LSB   8
`define CFG_FLD_IRQ_BIT     15

// ****************************************
// Reset values and responses
// ****************************************
`define CFG_RST_WORD        32'h0000_0000
`define CFG_RESP_OKAY       2'b00
`define CFG_RESP_SLVERR     2'b10

`endif

// >>> design/can_cfg_pkg.sv
// Types shared by the CAN bit timing and identifier configuration block.
// Assumes nothing beyond the configuration header.
package can_cfg_pkg;

	typedef enum logic [1:0]
	{
		SEG_SYNC,
		SEG_SAMPLE,
		SEG_PHASE2
	} seg_type;

	typedef logic [5:0] presc_type;
	typedef logic [3:0] seg1_type;
	typedef logic [2:0] seg2_type;

endpackage

// >>> design/quantum_divider.sv
// Time quantum divider: one-cycle enable pulse per time quantum.
// Assumes aclk at the rate in the configuration header.
`timescale 1ns/10ps
`include "can_cfg.svh"

module quantum_divider
(
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// Control
	input  wire logic                  run,
	input  wire can_cfg_pkg::presc_type prescaler,
	// Quantum pulse
	output logic                       tq_tick
);
	import can_cfg_pkg::*;

	localparam int CLKS_PER_REF = `CFG_CLKS_PER_REF;

	logic [8:0] count_r;
	logic [8:0] limit;

	// Quantum is prescaler periods of the 8 MHz reference
	assign limit = 9'(int'(prescaler) * CLKS_PER_REF - 1);

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !run)
			count_r <= 9'h000;
		else if (count_r >= limit)
			count_r <= 9'h000;
		else
			count_r <= count_r + 9'h001;
	end

	assign tq_tick = run && (count_r >= limit);

endmodule

// >>> design/bit_segment_seq.sv
// Bit period sequencer: sync, sample and phase-two segments in quanta.
// Assumes tq_tick is a one-cycle pulse per time quantum.
`timescale 1ns/10ps
`include "can_cfg.svh"

module bit_segment_seq
(
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// Control
	input  wire logic                  run,
	input  wire logic                  tq_tick,
	input  wire can_cfg_pkg::seg1_type sample_len,
	input  wire can_cfg_pkg::seg2_type phase_len,
	// Timing events
	output logic                       bit_start,
	output logic                       sample_point,
	output can_cfg_pkg::seg_type       segment
);
	import can_cfg_pkg::*;

	seg_type    seg_r;
	logic [3:0] cnt_r;
	logic       last_q;

	assign segment   = seg_r;
	assign bit_start = tq_tick && (seg_r == SEG_SYNC);
	always_comb
	begin
		unique case (seg_r)
			SEG_SYNC:   last_q = 1'b1;
			SEG_SAMPLE: last_q = (cnt_r == sample_len - 4'h1);
			SEG_PHASE2: last_q = (cnt_r == {1'b0, phase_len} - 4'h1);
			default:    last_q = 1'b1;
		endcase
	end

	// Sample at end of sample segment, or end of sync when it is empty
	assign sample_point = tq_tick && last_q &&
		((seg_r == SEG_SAMPLE) || (seg_r == SEG_SYNC && sample_len == 4'h0));

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !run)
		begin
			seg_r <= SEG_SYNC;
			cnt_r <= 4'h0;
		end
		else if (tq_tick)
		begin
			cnt_r <= last_q ? 4'h0 : cnt_r + 4'h1;
			if (last_q)
			begin
				unique case (seg_r)
					SEG_SYNC:
						seg_r <= (sample_len != 4'h0) ? SEG_SAMPLE :
							(phase_len != 3'h0) ? SEG_PHASE2 : SEG_SYNC;
					SEG_SAMPLE:
						seg_r <= (phase_len != 3'h0) ? SEG_PHASE2 : SEG_SYNC;
					SEG_PHASE2:
						seg_r <= SEG_SYNC;
					default:
						seg_r <= SEG_SYNC;
				endcase
			end
		end
	end

endmodule

// >>> design/can_bit_timing_id_config.sv
// CAN bit timing and identifier filter configuration with AXI4-Lite registers.
// Assumes a 40 MHz aclk, a synchronous active-low reset and a single master.
//
// Functional notes
// - Quantum equals 6-bit prescaler (0-63) periods of an 8 MHz reference.
// - Bit periods of eight to twenty-three quanta are supported.
// - Every bit starts with a one-quantum sync segment.
// - Bit is sync plus sample plus phase-two; bus sampled at sample end.
// - Sample segment length is a 4-bit quantum count, 0 to 15.
// - Phase-two length is a 3-bit quantum count, 0 to 7.
// - Typical settings from 1M down to 20K give the matching bit rate.
// - Low identifier field holds identifier bits 0 to 10.
// - Indexed low field selects 11-bit identifier, otherwise 29-bit extended.
// - Middle field holds bits 11 to 23, high field bits 24 to 28.
// - Frames match only on their complete identifier value.
// - Module address must equal the switch; value 33 is broadcast.
// - Start bit 0-64; indexed counts from the left end of frame.
// - Bit count 0-64; indexed enables interrupt mode.
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "can_cfg.svh"

module can_bit_timing_id_config
(
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// Address switch and bus line
	input  wire logic [5:0]            addr_switch,
	input  wire logic                  can_rx,
	// Received identifier for filtering
	input  wire logic [28:0]           rx_frame_id,
	input  wire logic                  rx_frame_ext,
	input  wire logic                  rx_id_valid,
	// Timing outputs
	output logic                       xcvr_enable,
	output logic                       tq_pulse,
	output logic                       bit_start,
	output logic                       sample_point,
	output logic                       sampled_bit,
	// Filter and frame field outputs
	output logic [28:0]                filter_id,
	output logic                       filter_extended,
	output logic                       id_hit,
	output logic [6:0]                 start_bit_pos,
	output logic [6:0]                 bit_count,
	output logic                       irq_mode,
	output logic                       addr_match,
	output logic                       addr_broadcast
);
	import can_cfg_pkg::*;

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = new_w[i*8 +: 8];
		return res;
	endfunction

	function automatic logic [6:0] clamp_edge(input logic [6:0] v);
		return (v > `CFG_EDGE_MAX) ? `CFG_EDGE_MAX : v;
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= `CFG_OFF_STATUS);
	endfunction

	// ****************************************
	// Configuration registers
	// ****************************************
	presc_type   presc_r;
	seg1_type    seg1_r;
	seg2_type    seg2_r;
	logic [10:0] id_low_r;
	logic        id_std_r;
	logic [12:0] id_mid_r;
	logic [4:0]  id_high_r;
	logic [6:0]  start_r;
	logic        start_left_r;
	logic [6:0]  count_r;
	logic        irq_mode_r;
	logic [5:0]  mod_addr_r;

	// ****************************************
	// Bus slave state
	// ****************************************
	logic        aw_held_r;
	logic [7:0]  aw_addr_r;
	logic        w_held_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [1:0]  rresp_r;
	logic [31:0] rdata_r;
	logic        wr_fire;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic [31:0] cur_word;
	logic [31:0] new_word;
	logic [31:0] rd_word;

	// ****************************************
	// Timing state
	// ****************************************
	logic        timing_run;
	logic        timing_ok;
	logic [4:0]  quanta_total;
	logic        tq_tick;
	logic        sampled_r;
	logic        id_hit_r;
	seg_type     segment;

	// ****************************************
	// Write channel
	// ****************************************
	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready  = !w_held_r && !bvalid_r;
	assign wr_addr  = aw_held_r ? aw_addr_r : s_axi_awaddr;
	assign wr_data  = w_held_r ? w_data_r : s_axi_wdata;
	assign wr_strb  = w_held_r ? w_strb_r : s_axi_wstrb;
	assign wr_fire  = !bvalid_r && (aw_held_r || s_axi_awvalid)
		&& (w_held_r || s_axi_wvalid);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_held_r  <= 1'b0;
			w_data_r  <= `CFG_RST_WORD;
			w_strb_r  <= 4'h0;
		end
		else if (wr_fire)
		begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_r <= 1'b0;
			bresp_r  <= `CFG_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_r <= 1'b1;
			bresp_r  <= (is_mapped(wr_addr) && wr_addr != `CFG_OFF_STATUS) ?
				`CFG_RESP_OKAY : `CFG_RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_r <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;

	// ****************************************
	// Register update
	// ****************************************
	always_comb
	begin
		cur_word = `CFG_RST_WORD;
		unique case (wr_addr)
			`CFG_OFF_TIMING:  cur_word = {17'h0, seg2_r, seg1_r, 2'h0, presc_r};
			`CFG_OFF_ID_LOW:  cur_word = {id_std_r, 20'h0, id_low_r};
			`CFG_OFF_ID_MID:  cur_word = {19'h0, id_mid_r};
			`CFG_OFF_ID_HIGH: cur_word = {27'h0, id_high_r};
			`CFG_OFF_FIELD:
				cur_word = {16'h0, irq_mode_r, count_r, start_left_r, start_r};
			`CFG_OFF_ADDR:    cur_word = {26'h0, mod_addr_r};
			default:          cur_word = `CFG_RST_WORD;
		endcase
	end

	assign new_word = merge_strb(cur_word, wr_data, wr_strb);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			presc_r <= 6'h00;
			seg1_r  <= 4'h0;
			seg2_r  <= 3'h0;
		end
		else if (wr_fire && wr_addr == `CFG_OFF_TIMING)
		begin
			presc_r <= new_word[`CFG_TIM_PRESC_LSB +: 6];
			seg1_r  <= new_word[`CFG_TIM_SEG1_LSB +: 4];
			seg2_r  <= new_word[`CFG_TIM_SEG2_LSB +: 3];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			id_low_r  <= 11'h000;
			id_std_r  <= 1'b0;
			id_mid_r  <= 13'h0000;
			id_high_r <= 5'h00;
		end
		else if (wr_fire)
		begin
			if (wr_addr == `CFG_OFF_ID_LOW)
			begin
				id_low_r <= new_word[10:0];
				id_std_r <= new_word[`CFG_ID_STD_BIT];
			end
			if (wr_addr == `CFG_OFF_ID_MID)
				id_mid_r <= new_word[12:0];
			if (wr_addr == `CFG_OFF_ID_HIGH)
				id_high_r <= new_word[4:0];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			start_r      <= 7'h00;
			start_left_r <= 1'b0;
			count_r      <= 7'h00;
			irq_mode_r   <= 1'b0;
			mod_addr_r   <= 6'h00;
		end
		else if (wr_fire)
		begin
			if (wr_addr == `CFG_OFF_FIELD)
			begin
				start_r      <= clamp_edge(new_word[`CFG_FLD_START_LSB +: 7]);
				start_left_r <= new_word[`CFG_FLD_LEFT_BIT];
				count_r      <= clamp_edge(new_word[`CFG_FLD_COUNT_LSB +: 7]);
				irq_mode_r   <= new_word[`CFG_FLD_IRQ_BIT];
			end
			if (wr_addr == `CFG_OFF_ADDR)
				mod_addr_r <= new_word[5:0];
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	assign s_axi_arready = !rvalid_r;

	always_comb
	begin
		rd_word = `CFG_RST_WORD;
		unique case (s_axi_araddr)
			`CFG_OFF_TIMING:  rd_word = {17'h0, seg2_r, seg1_r, 2'h0, presc_r};
			`CFG_OFF_ID_LOW:  rd_word = {id_std_r, 20'h0, id_low_r};
			`CFG_OFF_ID_MID:  rd_word = {19'h0, id_mid_r};
			`CFG_OFF_ID_HIGH: rd_word = {27'h0, id_high_r};
			`CFG_OFF_FIELD:
				rd_word = {16'h0, irq_mode_r, count_r, start_left_r, start_r};
			`CFG_OFF_ADDR:    rd_word = {26'h0, mod_addr_r};
			`CFG_OFF_STATUS:
				rd_word = {20'h0, quanta_total, sampled_r, addr_broadcast,
					addr_match, xcvr_enable, segment, timing_ok};
			default:          rd_word = `CFG_RST_WORD;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rresp_r  <= `CFG_RESP_OKAY;
			rdata_r  <= `CFG_RST_WORD;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_word;
			rresp_r  <= is_mapped(s_axi_araddr) ? `CFG_RESP_OKAY : `CFG_RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp  = rresp_r;
	assign s_axi_rdata  = rdata_r;

	// ****************************************
	// Bit timing
	// ****************************************
	assign quanta_total = 5'h01 + {1'b0, seg1_r} + {2'h0, seg2_r};
	assign timing_ok = (quanta_total >= `CFG_QUANTA_MIN)
		&& (quanta_total <= `CFG_QUANTA_MAX);
	assign timing_run  = (presc_r != 6'h00);
	assign xcvr_enable = timing_run;

	quantum_divider u_divider
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.run       (timing_run),
		.prescaler (presc_r),
		.tq_tick   (tq_tick)
	);

	bit_segment_seq u_segments
	(
		.aclk         (aclk),
		.aresetn      (aresetn),
		.run          (timing_run),
		.tq_tick      (tq_tick),
		.sample_len   (seg1_r),
		.phase_len    (seg2_r),
		.bit_start    (bit_start),
		.sample_point (sample_point),
		.segment      (segment)
	);

	assign tq_pulse = tq_tick;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sampled_r <= 1'b1;
		else if (sample_point)
			sampled_r <= can_rx;
	end

	assign sampled_bit = sampled_r;

	// ****************************************
	// Identifier filter and frame fields
	// ****************************************
	assign filter_extended = !id_std_r;
	assign filter_id = id_std_r ? {18'h0, id_low_r}
		: {id_high_r, id_mid_r, id_low_r};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			id_hit_r <= 1'b0;
		else
			id_hit_r <= rx_id_valid && (rx_frame_ext == filter_extended)
				&& (rx_frame_id == filter_id);
	end

	assign id_hit = id_hit_r;
	assign start_bit_pos = start_left_r ? `CFG_EDGE_MAX - start_r : start_r;
	assign bit_count = count_r;
	assign irq_mode  = irq_mode_r;
	assign addr_broadcast = (mod_addr_r == `CFG_ADDR_BCAST);
	assign addr_match = (mod_addr_r == addr_switch) || addr_broadcast;

endmodule

// >>> tb/can_cfg_checker.sv
// Concurrent checks on the CAN timing and identifier block, bound to its top.
// Assumes the single aclk domain and the synchronous active-low reset.
`timescale 1ns/10ps

module can_cfg_checker
(
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Far side
	input wire logic        can_rx,
	input wire logic [28:0] rx_frame_id,
	input wire logic        rx_frame_ext,
	input wire logic        rx_id_valid,
	// Timing
	input wire logic        xcvr_enable,
	input wire logic        tq_pulse,
	input wire logic        bit_start,
	input wire logic        sample_point,
	input wire logic        sampled_bit,
	// Filter and fields
	input wire logic [28:0] filter_id,
	input wire logic        filter_extended,
	input wire logic        id_hit,
	input wire logic [6:0]  start_bit_pos,
	input wire logic [6:0]  bit_count,
	input wire logic        addr_match,
	input wire logic        addr_broadcast
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_IDLE: assert property (!xcvr_enable |-> !tq_pulse)
		else $error("quantum pulse while transceiver idle");
	AST_TQ_GAP: assert property (tq_pulse |=> !tq_pulse [*4])
		else $error("quanta closer than five clocks");
	AST_SYNC: assert property (bit_start |-> tq_pulse)
		else $error("bit start off a quantum boundary");
	AST_SAMPLE_TQ: assert property (sample_point |-> tq_pulse)
		else $error("sample point off a quantum boundary");
	AST_SAMPLE: assert property (sample_point |=> sampled_bit == $past(can_rx))
		else $error("bus level not captured at sample point");
	AST_HIT: assert property (rx_id_valid |=> id_hit == ($past(rx_frame_id) ==
		$past(filter_id) && $past(rx_frame_ext) == $past(filter_extended)))
		else $error("identifier match wrong");
	AST_NO_HIT: assert property (!rx_id_valid |=> !id_hit)
		else $error("match without identifier");
	AST_STD: assert property (!filter_extended |-> filter_id[28:11] == 18'h0)
		else $error("upper identifier bits used in standard mode");
	AST_BCAST: assert property (addr_broadcast |-> addr_match)
		else $error("broadcast address not matched");
	AST_RANGE: assert property (start_bit_pos <= 7'h40 && bit_count <= 7'h40)
		else $error("frame field above 64");

	cover property (bit_start);
	cover property (id_hit);
	cover property (sample_point && !sampled_bit);
endmodule

bind can_bit_timing_id_config can_cfg_checker chk_i
(
	.aclk, .aresetn, .can_rx, .rx_frame_id, .rx_frame_ext, .rx_id_valid,
	.xcvr_enable, .tq_pulse, .bit_start, .sample_point, .sampled_bit, .filter_id,
	.filter_extended, .id_hit, .start_bit_pos, .bit_count, .addr_match, .addr_broadcast
);

// >>> tb/can_node_model.sv
// Other nodes on the bus: toggle the level each bit, offer identifiers on request.
// Assumes bit_start from the block and a one-cycle send from the bench.
`timescale 1ns/10ps

module can_node_model
(
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bench command
	input wire logic        send,
	input wire logic [28:0] tx_id,
	input wire logic        tx_ext,
	// Block timing
	input wire logic        bit_start,
	// Bus side
	output logic            can_rx,
	output logic [28:0]     rx_frame_id,
	output logic            rx_frame_ext,
	output logic            rx_id_valid
);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			can_rx <= 1'b1;
			rx_id_valid <= 1'b0;
			rx_frame_id <= 29'h0;
			rx_frame_ext <= 1'b0;
		end
		else
		begin
			if (bit_start)
				can_rx <= ~can_rx;
			rx_id_valid <= send;
			// Released identifier lines never hold the last value
			rx_frame_id <= send ? tx_id : ~rx_frame_id;
			rx_frame_ext <= send ? tx_ext : ~rx_frame_ext;
		end
	end
endmodule

// >>> tb/can_bit_timing_id_config_bench.sv
// Self-checking bench for the CAN timing and identifier block.
// Assumes the checker bind and the far-side model are compiled alongside.
`timescale 1ns/10ps
`include "can_cfg.svh"

module can_bit_timing_id_config_bench;
	import can_cfg_pkg::*;

	logic        aclk = 1'b0, aresetn = 1'b0, send = 1'b0, tx_ext = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [5:0]  addr_switch = 6'h05;
	logic [28:0] tx_id = 29'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        can_rx, rx_frame_ext, rx_id_valid, xcvr_enable, tq_pulse, bit_start;
	logic        sample_point, sampled_bit, filter_extended, id_hit, irq_mode;
	logic        addr_match, addr_broadcast;
	logic [28:0] rx_frame_id, filter_id;
	logic [6:0]  start_bit_pos, bit_count;
	int          failures = 0, check_count = 0;

	always #12.5 aclk = ~aclk;

	can_bit_timing_id_config dut
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.addr_switch, .can_rx, .rx_frame_id, .rx_frame_ext, .rx_id_valid, .xcvr_enable,
		.tq_pulse, .bit_start, .sample_point, .sampled_bit, .filter_id, .filter_extended,
		.id_hit, .start_bit_pos, .bit_count, .irq_mode, .addr_match, .addr_broadcast
	);

	can_node_model far
	(
		.aclk, .aresetn, .send, .tx_id, .tx_ext, .bit_start,
		.can_rx, .rx_frame_id, .rx_frame_ext, .rx_id_valid
	);

	task summarize;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Ready and answers are read at the negedge, acted on at the next rising edge
	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b)
		begin
			@(negedge aclk);
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
			s_axi_bready <= !b;
		end
	endtask

	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, v;
		ar = 1'b1;
		v = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!v)
		begin
			@(negedge aclk);
			ar = ar && !s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			s_axi_arvalid <= ar;
			s_axi_rready <= !v;
		end
	endtask

	task wait_ev(input logic smp, output int n);
		n = 0;
		do
		begin
			@(negedge aclk);
			n++;
		end
		while (!(smp ? sample_point : bit_start) && n < 9000);
	endtask

	task offer(input logic [28:0] id, input logic ext, input logic hit);
		@(posedge aclk);
		tx_id <= id;
		tx_ext <= ext;
		send <= 1'b1;
		@(posedge aclk);
		send <= 1'b0;
		@(posedge aclk);
		@(negedge aclk);
		chk("id hit", hit, id_hit);
	endtask

	task t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		chk("xcvr idle", 1'b0, xcvr_enable);
		chk("sampled idle", 1'b1, sampled_bit);
		for (int a = 0; a < 24; a += 4)
		begin
			axi_rd(8'(a), d, r);
			chk("reset word", `CFG_RST_WORD, d);
		end
		$display("reset test done");
	endtask

	task t_err;
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(`CFG_OFF_STATUS, 32'hffff_ffff, r);
		chk("status write", `CFG_RESP_SLVERR, r);
		axi_wr(8'h02, 32'h0000_0001, r);
		chk("unaligned", `CFG_RESP_SLVERR, r);
		axi_rd(8'h1c, d, r);
		chk("unmapped resp", `CFG_RESP_SLVERR, r);
		chk("unmapped data", 32'h0, d);
		$display("error test done");
	endtask

	task t_field;
		logic [1:0] r;
		axi_wr(`CFG_OFF_FIELD, 32'h0000_c040, r);
		chk("start right", 7'h40, start_bit_pos);
		chk("count max", 7'h40, bit_count);
		chk("irq on", 1'b1, irq_mode);
		axi_wr(`CFG_OFF_FIELD, 32'h0000_038a, r);
		chk("start left", 7'd54, start_bit_pos);
		chk("count", 7'd3, bit_count);
		chk("irq off", 1'b0, irq_mode);
		axi_wr(`CFG_OFF_FIELD, 32'h0000_7f7f, r);
		chk("start sat", 7'h40, start_bit_pos);
		chk("count sat", 7'h40, bit_count);
		$display("field test done");
	endtask

	task t_addr;
		logic [1:0] r;
		axi_wr(`CFG_OFF_ADDR, 32'h5, r);
		chk("match", 1'b1, addr_match);
		chk("not bcast", 1'b0, addr_broadcast);
		axi_wr(`CFG_OFF_ADDR, 32'h6, r);
		chk("mismatch", 1'b0, addr_match);
		axi_wr(`CFG_OFF_ADDR, 32'h21, r);
		chk("bcast match", 1'b1, addr_match);
		chk("bcast", 1'b1, addr_broadcast);
		$display("address test done");
	endtask

	task t_id;
		logic [1:0]  r;
		logic [28:0] id;
		id = {5'h15, 13'h0abc, 11'h123};
		axi_wr(`CFG_OFF_ID_LOW, 32'h123, r);
		axi_wr(`CFG_OFF_ID_MID, 32'h0abc, r);
		axi_wr(`CFG_OFF_ID_HIGH, 32'h15, r);
		chk("ext id", id, filter_id);
		chk("ext flag", 1'b1, filter_extended);
		offer(id, 1'b1, 1'b1);
		offer(id ^ 29'h1, 1'b1, 1'b0);
		offer(id ^ 29'h1000_0000, 1'b1, 1'b0);
		axi_wr(`CFG_OFF_ID_LOW, 32'h8000_0123, r);
		chk("std id", 29'h123, filter_id);
		chk("std flag", 1'b0, filter_extended);
		offer(29'h123, 1'b0, 1'b1);
		$display("identifier test done");
	endtask

	task t_timing;
		int         tp[8] = '{1, 1, 2, 4, 8, 16, 40, 63};
		int         s1[8] = '{5, 7, 5, 5, 5, 7, 7, 15};
		int         q;
		int         n;
		logic [1:0] r;
		logic [31:0] d;
		foreach (tp[i])
		begin
			q = tp[i] * `CFG_CLKS_PER_REF;
			axi_wr(`CFG_OFF_TIMING, 32'h2000 | (s1[i] << 8) | tp[i], r);
			chk("timing resp", `CFG_RESP_OKAY, r);
			chk("xcvr on", 1'b1, xcvr_enable);
			axi_rd(`CFG_OFF_STATUS, d, r);
			chk("timing ok", 1'b1, d[0]);
			chk("status xcvr", 1'b1, d[3]);
			chk("quanta total", 3 + s1[i], d[11:7]);
			wait_ev(1'b0, n);
			wait_ev(1'b0, n);
			wait_ev(1'b1, n);
			chk("sync to sample", s1[i] * q, n);
			wait_ev(1'b0, n);
			chk("sample to sync", 3 * q, n);
		end
		$display("timing test done");
	endtask

	task t_zero;
		int         n;
		logic [1:0] r;
		n = 0;
		axi_wr(`CFG_OFF_TIMING, 32'h0, r);
		repeat (60)
		begin
			@(negedge aclk);
			n += tq_pulse;
		end
		chk("idle pulses", 0, n);
		chk("xcvr off", 1'b0, xcvr_enable);
		$display("idle test done");
	endtask

	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_err;
		t_field;
		t_addr;
		t_id;
		t_timing;
		t_zero;
		summarize;
	end

	// Under 30000 cycles expected; cut off at 80000
	initial
	begin
		#2_000_000;
		failures++;
		summarize;
	end
endmodule
